// File: src/asc_channel.sv
// Behaviour
// - One start bit, then 7/8/9 data bits
// - Optional parity bit, odd or even
// - One or two stop bits
// - Internal rate is source over 16(n+1)
// - Source: clock /1, /2, /8, /32
// - External rate is pin clock over 16(n+1)
// - Flow: CTS gate, RTS output, or off
// - Send needs enable, data, and CTS low when the CTS gate is on
// - Receive needs enable and start bit
// - Select 0: interrupt on buffer load
// - Select 1: interrupt after last bit
// - Receive interrupt on buffer transfer
// - Overrun at bit before last stop
// - Overrun: buffer undefined, no interrupt
// - Framing error when stop bits missing
// - Parity error on wrong ones count
// - Summary flag ORs the three errors
// - LSB-first, or MSB-first for 8-bit characters
// - Data inversion spares start and stop
// - Line polarity inverts the RXD level always and the TXD level once the first transfer starts; CTS and RTS are not inverted
// - Channel 0 splits CTS and RTS pins
// - Transmit interrupt select bit placement
// - Mode codes 100, 101, 110
// - Buffers use bits 0..len-1
// - Output high until first transfer
`timescale 1ns/10ps
`default_nettype none
module asc_channel #(
	parameter int CHANNEL_ID = 0
) (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic [asc_pkg::ADDR_W-1:0] addr,
	input  wire logic [asc_pkg::DATA_W-1:0] wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic [asc_pkg::DATA_W-1:0]   rdata,
	input  wire logic                    rxd_i,
	output logic                         txd_o,
	output logic                         txd_oe,
	input  wire logic                    clk_pin_i,
	input  wire logic                    cts_b_i,
	input  wire logic                    alt_cts_b_i,
	output logic                         rts_b_o,
	output logic                         rts_oe,
	output logic                         tx_irq,
	output logic                         rx_irq
);
	import asc_pkg::*;

	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_PAR   = 5'h08,
		TX_STOP  = 5'h10
	} asc_tx_t;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} asc_rx_t;

	asc_baud_if bif ();

	logic [7:0]        mode_r;
	logic [7:0]        ctrl0_r;
	logic [7:0]        div_r;
	logic [7:0]        shared_r;
	logic              te_r;
	logic              re_r;
	logic              irs2_r;
	logic              inv_r;
	logic [15:0]       rdata_r;
	logic [15:0]       rd_val;
	logic [CHAR_W-1:0] txbuf_r;
	logic              tbe_r;
	asc_tx_t           tx_state_r;
	logic [CHAR_W-1:0] tx_shift_r;
	logic [3:0]        tx_bit_r;
	logic [3:0]        tx_tick_r;
	logic              tx_par_r;
	logic              tx_started_r;
	logic              tx_irq_r;
	logic              txd_o_r;
	logic              txd_oe_r;
	asc_rx_t           rx_state_r;
	logic [CHAR_W-1:0] rx_data_r;
	logic [3:0]        rx_bit_r;
	logic [3:0]        rx_tick_r;
	logic              rx_pbit_r;
	logic              rx_frm_acc_r;
	logic              rx_ovr_frame_r;
	logic [CHAR_W-1:0] rxbuf_r;
	logic              rxf_r;
	logic              ovr_r;
	logic              frm_r;
	logic              par_r;
	logic              rx_irq_r;
	logic              rts_b_r;
	logic              rx_s1_r;
	logic              rx_s2_r;
	logic              cts_s1_r;
	logic              cts_s2_r;
	logic              acts_s1_r;
	logic              acts_s2_r;
	logic [3:0]        len;
	logic [8:0]        mask;
	logic              async_ok;
	logic              pen;
	logic              podd;
	logic              stop2;
	logic              pol;
	logic              msb_first;
	logic              irs;
	logic              sep;
	logic              flow_on;
	logic              cts_gate;
	logic              cts_lvl;
	logic              tx_go;
	logic              tx_bit_end;
	logic [CHAR_W-1:0] tx_frame;
	logic              tx_line;
	logic              rx_lvl;
	logic              rx_samp;
	logic              rx_pre_last;
	logic [CHAR_W-1:0] rx_char;
	logic              rx_perr;

	// ==========================================
	// Configuration decode
	// only the three asynchronous codes enable the channel
	assign len       = char_len(mode_r[MODE_SMD_LSB +: 3]);
	assign mask      = len_mask(len);
	assign async_ok  = (len != 4'h0);
	assign pen       = mode_r[MODE_PEN];
	assign podd      = mode_r[MODE_PODD];
	assign stop2     = mode_r[MODE_STOP2];
	assign pol       = mode_r[MODE_POL];
	// order applies to 8-bit characters only
	assign msb_first = ctrl0_r[C0_MSB_FIRST] && (len == 4'h8);
	// channels 0 and 1 use the shared register, channel 2 its own
	assign irs       = (CHANNEL_ID == 2) ? irs2_r : ((CHANNEL_ID == 0) ? shared_r[0] : shared_r[1]);
	// split pins on channel 0 only
	assign sep       = (CHANNEL_ID == 0) && shared_r[SH_RCSP];
	assign flow_on   = ~ctrl0_r[C0_FLOW_OFF];
	assign cts_gate  = flow_on && (~ctrl0_r[C0_RTS_SEL] || sep);
	assign cts_lvl   = sep ? acts_s2_r : cts_s2_r;

	assign bif.src_sel = ctrl0_r[C0_SRC_LSB +: 2];
	assign bif.ext_sel = mode_r[MODE_CLOCK_DIRECTION_SELECT];
	assign bif.divisor = div_r;

	asc_baud_gen u_baud (
		.clk       (clk),
		.rst_b     (rst_b),
		.clk_pin_i (clk_pin_i),
		.bif       (bif)
	);

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_s1_r   <= 1'b1;
			rx_s2_r   <= 1'b1;
			cts_s1_r  <= 1'b1;
			cts_s2_r  <= 1'b1;
			acts_s1_r <= 1'b1;
			acts_s2_r <= 1'b1;
		end else begin
			rx_s1_r   <= rxd_i;
			rx_s2_r   <= rx_s1_r;
			cts_s1_r  <= cts_b_i;
			cts_s2_r  <= cts_s1_r;
			acts_s1_r <= alt_cts_b_i;
			acts_s2_r <= acts_s1_r;
		end
	end

	// ==========================================
	// Configuration registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r   <= RST_MODE;
			ctrl0_r  <= RST_CTRL0;
			div_r    <= RST_DIV;
			shared_r <= RST_SHARED;
			te_r     <= 1'b0;
			re_r     <= 1'b0;
			irs2_r   <= 1'b0;
			inv_r    <= 1'b0;
		end else if (wr) begin
			case (addr)
				OFF_MODE:   mode_r   <= wdata[7:0];
				OFF_CTRL0:  ctrl0_r  <= wdata[7:0];
				OFF_DIV:    div_r    <= wdata[7:0];
				OFF_SHARED: shared_r <= wdata[7:0];
				OFF_CTRL1: begin
					te_r   <= wdata[C1_TE];
					re_r   <= wdata[C1_RE];
					irs2_r <= wdata[C1_IRS];
					inv_r  <= wdata[C1_INV];
				end
				default: ;
			endcase
		end
	end

	// ==========================================
	// Read port, data valid only in the cycle after the strobe
	always_comb begin
		rd_val = 16'h0000;
		case (addr)
			OFF_MODE:   rd_val[7:0] = mode_r;
			OFF_CTRL0: begin
				rd_val[7:0]      = ctrl0_r;
				rd_val[C0_TXEPT] = (tx_state_r == TX_IDLE);
			end
			OFF_DIV:    rd_val[7:0] = div_r;
			OFF_CTRL1: begin
				rd_val[C1_TE]  = te_r;
				rd_val[C1_TBE] = tbe_r;
				rd_val[C1_RE]  = re_r;
				rd_val[C1_RXF] = rxf_r;
				rd_val[C1_IRS] = irs2_r;
				rd_val[C1_INV] = inv_r;
			end
			OFF_RXBUF: begin
				rd_val[CHAR_W-1:0] = rxbuf_r;
				rd_val[RB_OVR]     = ovr_r;
				rd_val[RB_FRM]     = frm_r;
				rd_val[RB_PAR]     = par_r;
				rd_val[RB_SUM]     = ovr_r | frm_r | par_r;
			end
			OFF_SHARED: rd_val[7:0] = shared_r;
			default: ;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rd ? rd_val : 16'h0000;
		end
	end

	// ==========================================
	// Transmitter
	// start condition
	assign tx_go      = (tx_state_r == TX_IDLE) && async_ok && te_r && ~tbe_r && ~(cts_gate && cts_lvl);
	assign tx_bit_end = bif.tick16 && (tx_tick_r == OVS_LAST);
	// order, then invert only the used data bits
	assign tx_frame   = (order_bits(txbuf_r, msb_first) ^ (inv_r ? mask : 9'h000)) & mask;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_state_r   <= TX_IDLE;
			tx_shift_r   <= 9'h000;
			tx_bit_r     <= 4'h0;
			tx_tick_r    <= 4'h0;
			tx_par_r     <= 1'b0;
			tx_started_r <= 1'b0;
			tx_irq_r     <= 1'b0;
			tbe_r        <= 1'b1;
			txbuf_r      <= 9'h000;
		end else begin
			tx_irq_r <= 1'b0;
			if (tx_state_r != TX_IDLE && bif.tick16) begin
				tx_tick_r <= tx_tick_r + 4'h1;
			end
			if (!async_ok) begin
				tx_state_r   <= TX_IDLE;
				tx_started_r <= 1'b0;
			end else begin
				unique case (tx_state_r)
					TX_IDLE: begin
						if (tx_go) begin
							tx_shift_r   <= tx_frame;
							// parity sense over the bits as sent
							tx_par_r     <= (^tx_frame) ^ podd;
							tx_tick_r    <= 4'h0;
							tx_state_r   <= TX_START;
							tx_started_r <= 1'b1;
							tbe_r        <= 1'b1;
							if (!irs) begin
								tx_irq_r <= 1'b1;
							end
						end
					end
					TX_START: begin
						if (tx_bit_end) begin
							tx_bit_r   <= 4'h0;
							tx_state_r <= TX_DATA;
						end
					end
					TX_DATA: begin
						if (tx_bit_end) begin
							tx_shift_r <= tx_shift_r >> 1;
							tx_bit_r   <= tx_bit_r + 4'h1;
							if (tx_bit_r == len - 4'h1) begin
								tx_bit_r   <= 4'h0;
								tx_state_r <= pen ? TX_PAR : TX_STOP;
							end
						end
					end
					TX_PAR: begin
						if (tx_bit_end) begin
							tx_state_r <= TX_STOP;
						end
					end
					TX_STOP: begin
						if (tx_bit_end) begin
							tx_bit_r <= tx_bit_r + 4'h1;
							if (tx_bit_r == {3'h0, stop2}) begin
								tx_state_r <= TX_IDLE;
								if (irs) begin
									tx_irq_r <= 1'b1;
								end
							end
						end
					end
				endcase
			end
			// A write in the load cycle keeps its new data pending
			if (wr && addr == OFF_TXBUF) begin
				txbuf_r <= wdata[CHAR_W-1:0] & mask;
				tbe_r   <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (tx_state_r)
			TX_START: tx_line = 1'b0;
			TX_DATA:  tx_line = tx_shift_r[0];
			TX_PAR:   tx_line = tx_par_r;
			default:  tx_line = 1'b1;
		endcase
	end

	// line high before first frame, then polarity applied
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txd_o_r  <= 1'b1;
			txd_oe_r <= 1'b0;
		end else if (ctrl0_r[C0_OPEN_DR]) begin
			txd_o_r  <= 1'b0;
			txd_oe_r <= tx_started_r && ~(tx_line ^ pol);
		end else begin
			txd_o_r  <= tx_started_r ? (tx_line ^ pol) : 1'b1;
			txd_oe_r <= 1'b1;
		end
	end

	// ==========================================
	// Receiver
	// input polarity
	assign rx_lvl      = rx_s2_r ^ pol;
	// sample at the centre of each bit
	assign rx_samp     = bif.tick16 && (rx_tick_r == OVS_LAST);
	assign rx_pre_last = (rx_state_r == RX_DATA && rx_bit_r == len - 4'h1 && !pen && !stop2)
	                   || (rx_state_r == RX_PAR && !stop2)
	                   || (rx_state_r == RX_STOP && rx_bit_r == 4'h0 && stop2);
	assign rx_char     = order_bits((rx_data_r ^ (inv_r ? mask : 9'h000)) & mask, msb_first);
	// ones over character and parity against the sense
	assign rx_perr     = pen && (((^(rx_data_r & mask)) ^ rx_pbit_r) != podd);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_state_r     <= RX_IDLE;
			rx_data_r      <= 9'h000;
			rx_bit_r       <= 4'h0;
			rx_tick_r      <= 4'h0;
			rx_pbit_r      <= 1'b0;
			rx_frm_acc_r   <= 1'b0;
			rx_ovr_frame_r <= 1'b0;
			rxbuf_r        <= 9'h000;
			rxf_r          <= 1'b0;
			ovr_r          <= 1'b0;
			frm_r          <= 1'b0;
			par_r          <= 1'b0;
			rx_irq_r       <= 1'b0;
		end else begin
			rx_irq_r <= 1'b0;
			if (rd && addr == OFF_RXBUF) begin
				rxf_r <= 1'b0;
			end
			if (wr && addr == OFF_CTRL1 && !wdata[C1_RE]) begin
				ovr_r <= 1'b0;
				frm_r <= 1'b0;
				par_r <= 1'b0;
			end
			if (rx_state_r != RX_IDLE && bif.tick16) begin
				rx_tick_r <= rx_tick_r + 4'h1;
			end
			// overrun at the bit before the last stop
			if (rx_samp && rx_pre_last && rxf_r) begin
				ovr_r          <= 1'b1;
				rx_ovr_frame_r <= 1'b1;
			end
			if (!async_ok) begin
				rx_state_r <= RX_IDLE;
			end else begin
				unique case (rx_state_r)
					RX_IDLE: begin
						if (re_r && !rx_lvl) begin
							rx_tick_r      <= 4'h0;
							rx_frm_acc_r   <= 1'b0;
							rx_ovr_frame_r <= 1'b0;
							rx_data_r      <= 9'h000;
							rx_state_r     <= RX_START;
						end
					end
					// confirm start bit near its middle
					RX_START: begin
						if (bif.tick16 && rx_tick_r == OVS_MID) begin
							rx_tick_r  <= 4'h0;
							rx_bit_r   <= 4'h0;
							rx_state_r <= rx_lvl ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (rx_samp) begin
							rx_data_r[rx_bit_r] <= rx_lvl;
							rx_bit_r            <= rx_bit_r + 4'h1;
							if (rx_bit_r == len - 4'h1) begin
								rx_bit_r   <= 4'h0;
								rx_state_r <= pen ? RX_PAR : RX_STOP;
							end
						end
					end
					RX_PAR: begin
						if (rx_samp) begin
							rx_pbit_r  <= rx_lvl;
							rx_state_r <= RX_STOP;
						end
					end
					RX_STOP: begin
						if (rx_samp) begin
							rx_bit_r     <= rx_bit_r + 4'h1;
							rx_frm_acc_r <= rx_frm_acc_r | ~rx_lvl;
							if (rx_bit_r == {3'h0, stop2}) begin
								rx_state_r <= RX_IDLE;
								// buffer overwritten, content undefined on overrun
								rxbuf_r    <= rx_char;
								rxf_r      <= 1'b1;
								frm_r      <= rx_frm_acc_r | ~rx_lvl;
								par_r      <= rx_perr;
								rx_irq_r   <= ~(rx_ovr_frame_r || (rx_pre_last && rxf_r));
							end
						end
					end
				endcase
			end
		end
	end

	// request-to-send: low while a character can be accepted
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rts_b_r <= 1'b1;
		end else begin
			rts_b_r <= ~(re_r && ~rxf_r);
		end
	end

	// ==========================================
	// Outputs
	assign rdata   = rdata_r;
	assign txd_o   = txd_o_r;
	assign txd_oe  = txd_oe_r;
	assign rts_b_o = rts_b_r;
	// pin released to general I/O when flow control is off
	assign rts_oe  = flow_on && (ctrl0_r[C0_RTS_SEL] || sep);
	assign tx_irq  = tx_irq_r;
	assign rx_irq  = rx_irq_r;
endmodule
`default_nettype wire

// File: src/asc_pkg.sv
`default_nettype none
package asc_pkg;

	// ==========================================
	// Register bus
	localparam int          ADDR_W      = 3;
	localparam int          DATA_W      = 16;
	localparam int          CHAR_W      = 9;
	localparam logic [2:0]  OFF_MODE    = 3'h0;
	localparam logic [2:0]  OFF_CTRL0   = 3'h1;
	localparam logic [2:0]  OFF_DIV     = 3'h2;
	localparam logic [2:0]  OFF_CTRL1   = 3'h3;
	localparam logic [2:0]  OFF_TXBUF   = 3'h4;
	localparam logic [2:0]  OFF_RXBUF   = 3'h5;
	localparam logic [2:0]  OFF_SHARED  = 3'h6;

	// ==========================================
	// Field positions
	localparam int          MODE_SMD_LSB = 0;
	localparam int          MODE_CLOCK_DIRECTION_SELECT   = 3;
	localparam int          MODE_STOP2   = 4;
	localparam int          MODE_PODD    = 5;
	localparam int          MODE_PEN     = 6;
	localparam int          MODE_POL     = 7;
	localparam int          C0_SRC_LSB   = 0;
	localparam int          C0_RTS_SEL   = 2;
	localparam int          C0_TXEPT     = 3;
	localparam int          C0_FLOW_OFF  = 4;
	localparam int          C0_OPEN_DR   = 5;
	localparam int          C0_MSB_FIRST = 7;
	localparam int          C1_TE        = 0;
	localparam int          C1_TBE       = 1;
	localparam int          C1_RE        = 2;
	localparam int          C1_RXF       = 3;
	localparam int          C1_IRS       = 4;
	localparam int          C1_INV       = 6;
	localparam int          RB_OVR       = 12;
	localparam int          RB_FRM       = 13;
	localparam int          RB_PAR       = 14;
	localparam int          RB_SUM       = 15;
	localparam int          SH_RCSP      = 6;

	// ==========================================
	// Reset values and codes
	localparam logic [7:0]  RST_MODE    = 8'h00;
	localparam logic [7:0]  RST_CTRL0   = 8'h00;
	localparam logic [7:0]  RST_DIV     = 8'h00;
	localparam logic [7:0]  RST_SHARED  = 8'h00;
	localparam logic [2:0]  SMD_7       = 3'h4;
	localparam logic [2:0]  SMD_8       = 3'h5;
	localparam logic [2:0]  SMD_9       = 3'h6;
	localparam logic [1:0]  SRC_DIV1    = 2'h0;
	localparam logic [1:0]  SRC_DIV2    = 2'h1;
	localparam logic [1:0]  SRC_DIV8    = 2'h2;
	localparam logic [1:0]  SRC_DIV32   = 2'h3;
	localparam logic [4:0]  PRE_DIV2    = 5'h01;
	localparam logic [4:0]  PRE_DIV8    = 5'h07;
	localparam logic [4:0]  PRE_DIV32   = 5'h1F;
	// Sixteen ticks per bit; start bit confirmed at the eighth
	localparam logic [3:0]  OVS_LAST    = 4'hF;
	localparam logic [3:0]  OVS_MID     = 4'h7;

	function automatic logic [3:0] char_len(input logic [2:0] smd);
		case (smd)
			SMD_7:   char_len = 4'h7;
			SMD_8:   char_len = 4'h8;
			SMD_9:   char_len = 4'h9;
			default: char_len = 4'h0;
		endcase
	endfunction

	function automatic logic [8:0] len_mask(input logic [3:0] len);
		case (len)
			4'h7:    len_mask = 9'h07F;
			4'h8:    len_mask = 9'h0FF;
			4'h9:    len_mask = 9'h1FF;
			default: len_mask = 9'h000;
		endcase
	endfunction

	// Reverses the low byte for most-significant-first shifting
	function automatic logic [8:0] order_bits(input logic [8:0] d, input logic msb);
		logic [8:0] r;
		r = d;
		if (msb) begin
			for (int i = 0; i < 8; i++) begin
				r[i] = d[7 - i];
			end
		end
		order_bits = r;
	endfunction

endpackage
`default_nettype wire

// File: src/asc_baud_if.sv
`timescale 1ns/10ps
`default_nettype none
interface asc_baud_if;
	logic [1:0] src_sel;
	logic       ext_sel;
	logic [7:0] divisor;
	logic       tick16;

	modport gen  (input src_sel, input ext_sel, input divisor, output tick16);
	modport user (output src_sel, output ext_sel, output divisor, input tick16);
endinterface
`default_nettype wire

// File: src/asc_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
module asc_baud_gen (
	input  wire logic   clk,
	input  wire logic   rst_b,
	input  wire logic   clk_pin_i,
	asc_baud_if.gen     bif
);
	import asc_pkg::*;

	logic       pin_s1_r;
	logic       pin_s2_r;
	logic       pin_s3_r;
	logic [4:0] pre_r;
	logic [7:0] div_cnt_r;
	logic       tick_r;
	logic       int_tick;
	logic       src_tick;

	// ==========================================
	// External clock pin, synchronised then edge detected
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_s3_r <= 1'b0;
		end else begin
			pin_s1_r <= clk_pin_i;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	// ==========================================
	// Prescaler
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_r <= 5'h00;
		end else begin
			pre_r <= pre_r + 5'h01;
		end
	end

	always_comb begin
		unique case (bif.src_sel)
			SRC_DIV1:  int_tick = 1'b1;
			SRC_DIV2:  int_tick = (pre_r[0] == PRE_DIV2[0]);
			SRC_DIV8:  int_tick = (pre_r[2:0] == PRE_DIV8[2:0]);
			SRC_DIV32: int_tick = (pre_r == PRE_DIV32);
		endcase
	end

	// external pin clock replaces the internal source
	assign src_tick = bif.ext_sel ? (pin_s2_r & ~pin_s3_r) : int_tick;

	// ==========================================
	// divide by n+1; the channel divides by sixteen more
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_r <= 8'h00;
			tick_r    <= 1'b0;
		end else begin
			tick_r <= 1'b0;
			if (src_tick) begin
				if (div_cnt_r == 8'h00) begin
					div_cnt_r <= bif.divisor;
					tick_r    <= 1'b1;
				end else begin
					div_cnt_r <= div_cnt_r - 8'h01;
				end
			end
		end
	end

	assign bif.tick16 = tick_r;
endmodule
`default_nettype wire

// File: verification/asc_chan_sva.sv
`timescale 1ns/10ps
`default_nettype none
module asc_chan_sva (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic                      wr,
	input  wire logic                      rd,
	input  wire logic [asc_pkg::DATA_W-1:0] rdata,
	input  wire logic                      txd_o,
	input  wire logic                      txd_oe,
	input  wire logic                      rts_b_o,
	input  wire logic                      rts_oe,
	input  wire logic                      tx_irq,
	input  wire logic                      rx_irq
);
	import asc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ==========================================
	// Port relations
	read_data_idle_a: assert property (!$past(rd) |-> rdata == '0)
		else $error("read data not zero outside a read answer");
	tx_irq_pulse_a: assert property (tx_irq |=> !tx_irq)
		else $error("transmit interrupt longer than one cycle");
	rx_irq_pulse_a: assert property (rx_irq |=> !rx_irq)
		else $error("receive interrupt longer than one cycle");
	// A bit is at least sixteen fast cycles, so eight is a safe floor
	bit_hold_a: assert property ($changed(txd_o) |=> $stable(txd_o) [*8])
		else $error("serial output changed too soon");
	flow_config_a: assert property ($changed(rts_oe) |-> $past(wr))
		else $error("flow pin enable moved without a write");
	released_low_a: assert property ($past(rst_b) && !txd_oe |-> !txd_o)
		else $error("serial output released while not low");
	rts_full_a: assert property (rx_irq && rts_oe |-> ##[0:1] rts_b_o)
		else $error("request to send not high with character waiting");
	rts_cause_a: assert property ($rose(rts_b_o) && rts_oe && !$past(wr) && !$past(wr, 2)
		|-> rx_irq || $past(rx_irq))
		else $error("request to send rose without a received character");
endmodule
bind asc_channel asc_chan_sva chk (.clk(clk), .rst_b(rst_b), .wr(wr), .rd(rd), .rdata(rdata),
	.txd_o(txd_o), .txd_oe(txd_oe), .rts_b_o(rts_b_o), .rts_oe(rts_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// File: verification/asc_peer.sv
`timescale 1ns/10ps
`default_nettype none
module asc_peer (
	input  wire logic clk,
	input  wire logic line_i,
	output logic      rxd_o,
	output logic      cts_b_o
);
	int          bt = 16;
	int          len = 10;
	int          nfr = 0;
	logic [12:0] got;

	initial begin
		rxd_o = 1'b1;
		cts_b_o = 1'b0;
	end

	// ==========================================
	// Frames out and in
	// whole frames
	task automatic send(input logic [12:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			rxd_o <= f[i];
			repeat (bt) @(posedge clk);
		end
		rxd_o <= 1'b1;
	endtask

	// Samples at bit centres; no wait after the last stop so frames may abut
	always begin
		@(negedge line_i);
		repeat (bt / 2) @(posedge clk);
		got[0] = line_i;
		for (int i = 1; i < len; i++) begin
			repeat (bt) @(posedge clk);
			got[i] = line_i;
		end
		nfr++;
	end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import asc_pkg::*;
	logic              clk, rst_b, wr, rd, cts_b, rxd, line;
	logic              txd_o, txd_oe, rts_b_o, rts_oe, tx_irq, rx_irq;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	int                num_errors = 0;
	int                comparisons = 0;
	int                nrx = 0;
	int                ntx = 0;

	assign line = txd_oe ? txd_o : 1'b1;
	asc_channel uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.rxd_i(rxd), .txd_o(txd_o), .txd_oe(txd_oe), .clk_pin_i(1'b0), .cts_b_i(cts_b), .alt_cts_b_i(1'b1),
		.rts_b_o(rts_b_o), .rts_oe(rts_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
	asc_peer peer (.clk(clk), .line_i(line), .rxd_o(rxd), .cts_b_o(cts_b));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rx_irq === 1'b1) nrx++;
		if (tx_irq === 1'b1) ntx++;
	end

	// ==========================================
	// Helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [15:0] mk, input logic [15:0] exp, input string what);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata & mk, exp, what);
	endtask
	task automatic waitf(input int k);
		int c;
		c = 0;
		while (peer.nfr == k && c < 5000) begin
			@(posedge clk);
			c++;
		end
		check(16'(peer.nfr - k), 16'h0001, "frame count");
	endtask
	function automatic logic [12:0] frame(input logic [8:0] d, input int n, input logic pe, po);
		logic [12:0] f;
		logic        p;
		f = 13'h1FFE;
		p = po;
		for (int k = 0; k < n; k++) begin
			f[k + 1] = d[k];
			p ^= d[k];
		end
		if (pe) f[n + 1] = p;
		return f;
	endfunction
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		results();
	end

	// ==========================================
	// Main sequence
	initial begin
		logic [8:0]  d, dd, msk;
		logic [15:0] lm;
		logic        pe, po, s2;
		logic [2:0]  smd;
		int          n, l, k, m, dv;
		rst_b = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		void'($urandom(32'h3FE4ACA6));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rchk(OFF_CTRL1, 16'hFFFF, 16'h0002, "ctrl1 reset");
		rchk(3'h7, 16'hFFFF, 16'h0000, "unmapped");
		dv = $urandom_range(2);
		peer.bt = 16 * (dv + 1);
		wreg(OFF_DIV, 16'(dv));
		wreg(OFF_CTRL0, 16'h0000);
		wreg(OFF_CTRL1, 16'h0005);
		for (int t = 0; t < 6; t++) begin
			n = 7 + t % 3;
			smd = SMD_7 + 3'(t % 3);
			msk = 9'h1FF >> (9 - n);
			pe = (t == 3) ? 1'b1 : 1'($urandom_range(1));
			po = 1'($urandom_range(1));
			s2 = 1'($urandom_range(1));
			l = n + 2 + int'(pe) + int'(s2);
			lm = 16'((1 << l) - 1);
			peer.len = l;
			d = ((t == 0) ? 9'h1FF : 9'($urandom)) & msk;
			dd = (t == 5) ? d ^ msk : d;
			if (t == 4) begin
				for (int i = 0; i < 8; i++) begin
					dd[i] = d[7 - i];
				end
			end
			if (t == 1 || t == 5) wreg(OFF_CTRL0, 16'h0004);
			// data inversion on the last pass
			if (t == 5) wreg(OFF_CTRL1, 16'h0045);
			wreg(OFF_MODE, {8'h00, 1'b0, pe, po, s2, 1'b0, smd});
			if (t == 4) wreg(OFF_CTRL0, 16'h0084);
			k = peer.nfr;
			m = ntx;
			if (t == 0) peer.cts_b_o <= 1'b1;
			wreg(OFF_TXBUF, 16'(d));
			if (t == 0) begin
				repeat (peer.bt * 4) @(posedge clk);
				rchk(OFF_CTRL1, 16'hFFFF, 16'h0005, "blocked by cts");
				peer.cts_b_o <= 1'b0;
			end
			waitf(k);
			check(16'(peer.got) & lm, 16'(frame(dd, n, pe, po)) & lm, "tx frame");
			check(16'(ntx - m), 16'h0001, "tx irq");
			m = nrx;
			peer.send(frame(dd, n, pe, po) ^ ((t == 3) ? 13'h0001 << (n + 1) : (t == 4) ? 13'h0001 << (l - 1) : '0), l);
			repeat (4) @(posedge clk);
			check(16'(nrx - m), 16'h0001, "rx irq");
			if (t > 0) check(16'({rts_oe, rts_b_o}), 16'h0003, "rts full");
			rchk(OFF_RXBUF, 16'hFFFF, {t == 3 || t == 4, t == 3, t == 4, 4'h0, d}, "rx buffer");
		end
		m = nrx;
		peer.send(frame(9'h055, n, pe, po), l);
		// One idle cycle so the line is not assigned twice in one step
		@(posedge clk);
		peer.send(frame(9'h0AA, n, pe, po), l);
		repeat (4) @(posedge clk);
		check(16'(nrx - m), 16'h0001, "overrun irq");
		rchk(OFF_RXBUF, 16'hF000, 16'h9000, "overrun flags");
		wreg(OFF_SHARED, 16'h0001);
		k = peer.nfr;
		m = ntx;
		wreg(OFF_TXBUF, 16'h0033);
		waitf(k);
		check(16'(ntx - m), 16'h0000, "irq before end");
		repeat (peer.bt * 2) @(posedge clk);
		check(16'(ntx - m), 16'h0001, "irq after end");
		wreg(OFF_CTRL0, 16'h0020);
		repeat (2) @(posedge clk);
		#1 check(16'({rts_oe, txd_oe, txd_o}), 16'h0000, "open drain idle");
		results();
	end
endmodule
`default_nettype wire
